/* File: core/nvs_ctrl.sv */
// nested virtualisation controls and forced writeback attribute combiner
// assumes all query inputs come from logic on clk_sys_in; answers one cycle later
`timescale 1ns/100ps
module nvs_ctrl import nvs_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // context
  input wire logic guest_kernel_level_in,
  input wire logic hyp_level_enabled_in,
  // access classification
  input wire logic acc_valid_in,
  input wire logic [2:0] acc_kind_in,
  input wire logic acc_implemented_in,
  input wire logic acc_other_trap_in,
  output logic acc_done_out,
  output logic [2:0] acc_action_out,
  output logic [5:0] acc_ec_out,
  // guest exception entry
  input wire logic exc_valid_in,
  output logic exc_done_out,
  output logic [1:0] exc_mode_out,
  // stage 1 / stage 2 attribute combine
  input wire logic attr_valid_in,
  input wire logic s1_device_in,
  input wire logic [1:0] s1_dev_kind_in,
  input wire logic [1:0] s1_inner_in,
  input wire logic [1:0] s1_outer_in,
  input wire logic [1:0] s1_alloc_in,
  input wire logic [5:0] s2_attr_in,
  input wire logic s2_secure_in,
  output logic attr_done_out,
  output logic fin_device_out,
  output logic [1:0] fin_dev_kind_out,
  output logic [1:0] fin_inner_out,
  output logic [1:0] fin_outer_out,
  output logic [1:0] fin_alloc_out,
  // guest descriptor reinterpretation
  input wire logic desc_valid_in,
  input wire logic [63:0] desc_in,
  input wire logic desc_is_table_in,
  input wire logic hier_perm_en_in,
  output logic desc_done_out,
  output logic [63:0] desc_out,
  output logic priv_execute_never_out,
  output logic user_execute_never_out,
  // privilege state effects
  input wire logic priv_access_never_state_in,
  output logic pan_effective_out,
  output logic unpriv_as_priv_out
);

  // whole block state
  typedef struct packed {
    logic forced_writeback;
    logic nv2;
    logic at;
    logic nv1;
    logic nv;
    logic [31:0] rdata;
    logic acc_done;
    nvs_action_e acc_action;
    logic [5:0] acc_ec;
    logic exc_done;
    logic [1:0] exc_mode;
    logic attr_done;
    logic fin_dev;
    logic [1:0] fin_kind;
    logic [1:0] fin_inner;
    logic [1:0] fin_outer;
    logic [1:0] fin_alloc;
    logic desc_done;
    logic [63:0] desc;
    logic priv_execute_never;
    logic user_execute_never;
    logic pan_eff;
    logic unpriv_priv;
  } nvs_state_s;

  nvs_state_s st_r; // registered state
  nvs_state_s st_nxt; // next state

  // effective controls
  logic nv_eff; // trap control as seen by logic
  logic nv1_eff; // aux control as seen by logic
  logic nv2_eff; // redirect as seen by logic
  logic both_nv; // aux and trap both one
  logic [31:0] cfg_hi; // stored fields in word layout
  logic [31:0] eff_word; // effective fields in word layout
  logic [1:0] s2_code; // stage 2 bits 3:2
  logic s1_cacheable; // stage 1 gave a cacheable type
  nvs_acc_kind_e acc_kind; // typed access kind

  // effective values of the nested controls
  always_comb begin
    nv_eff = st_r.nv;
    nv1_eff = st_r.nv1;
    // aux alone: selectable permitted behaviour
    if (st_r.nv1 && !st_r.nv) begin
      if (NVS_AUX_ONLY_MODE == 2'h0) begin
        nv_eff = 1'b1;
      end else if (NVS_AUX_ONLY_MODE == 2'h1) begin
        nv1_eff = 1'b0;
      end
    end
    // redirect only counts while the trap control is on
    nv2_eff = st_r.nv2 && nv_eff;
    both_nv = nv_eff && nv1_eff;
  end

  // readback words; cfg_hi shows stored values, eff_word shows effective values
  always_comb begin
    cfg_hi = 32'h0000_0000;
    cfg_hi[NVS_BIT_FWB] = st_r.forced_writeback;
    cfg_hi[NVS_BIT_NV2] = st_r.nv2;
    cfg_hi[NVS_BIT_AT] = st_r.at;
    cfg_hi[NVS_BIT_NV1] = st_r.nv1;
    cfg_hi[NVS_BIT_NV] = st_r.nv;
    cfg_hi = cfg_hi & NVS_IMPL_MASK;
    eff_word = 32'h0000_0000;
    eff_word[NVS_BIT_FWB] = st_r.forced_writeback;
    eff_word[NVS_BIT_NV2] = nv2_eff;
    eff_word[NVS_BIT_AT] = st_r.at;
    eff_word[NVS_BIT_NV1] = nv1_eff;
    eff_word[NVS_BIT_NV] = nv_eff;
  end

  assign s2_code = s2_attr_in[3:2];
  assign s1_cacheable = !s1_device_in && (s1_inner_in != NVS_CACHE_NC ||
    s1_outer_in != NVS_CACHE_NC);
  assign acc_kind = nvs_acc_kind_e'(acc_kind_in);

  // next-state logic for every part of the block
  always_comb begin
    st_nxt = st_r;
    // register port
    if (reg_wr_in && reg_addr_in == NVS_OFF_CFG_HI) begin
      st_nxt.forced_writeback = reg_wdata_in[NVS_BIT_FWB];
      st_nxt.nv2 = reg_wdata_in[NVS_BIT_NV2];
      st_nxt.at = reg_wdata_in[NVS_BIT_AT];
      st_nxt.nv1 = reg_wdata_in[NVS_BIT_NV1];
      st_nxt.nv = reg_wdata_in[NVS_BIT_NV];
    end
    st_nxt.rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      if (reg_addr_in == NVS_OFF_CFG_LO) begin
        st_nxt.rdata = 32'h0000_0000; // no fields held here
      end else if (reg_addr_in == NVS_OFF_CFG_HI) begin
        st_nxt.rdata = cfg_hi;
      end else if (reg_addr_in == NVS_OFF_EFFECT) begin
        st_nxt.rdata = eff_word;
      end else begin
        st_nxt.rdata = 32'h0000_0000; // unmapped
      end
    end

    // access classification, highest priority first
    st_nxt.acc_done = acc_valid_in;
    st_nxt.acc_action = NVS_ACT_NONE;
    st_nxt.acc_ec = 6'h00;
    if (acc_valid_in && guest_kernel_level_in) begin
      if (!acc_implemented_in && acc_kind != NVS_ACC_OTHER) begin
        st_nxt.acc_action = NVS_ACT_UNDEF;
      end else if (acc_other_trap_in) begin
        st_nxt.acc_action = NVS_ACT_OTHER_TRAP;
      end else if (nv2_eff && (acc_kind == NVS_ACC_HYP_REG ||
          (acc_kind == NVS_ACC_ALIAS_REG && !nv1_eff))) begin
        st_nxt.acc_action = NVS_ACT_TRANSFORM;
      end else if (hyp_level_enabled_in && st_r.at && acc_kind == NVS_ACC_S1_XLATE) begin
        st_nxt.acc_action = NVS_ACT_TRAP;
        st_nxt.acc_ec = NVS_EC_SYSREG;
      end else if (hyp_level_enabled_in && !nv2_eff && nv1_eff &&
          acc_kind == NVS_ACC_LISTED_REG) begin
        st_nxt.acc_action = NVS_ACT_TRAP;
        st_nxt.acc_ec = NVS_EC_SYSREG;
      end else if (hyp_level_enabled_in && !nv2_eff && nv_eff &&
          (acc_kind == NVS_ACC_HYP_REG || acc_kind == NVS_ACC_ALIAS_REG)) begin
        st_nxt.acc_action = NVS_ACT_TRAP;
        st_nxt.acc_ec = NVS_EC_SYSREG;
      end
    end

    // saved mode bits for guest-to-guest exceptions
    st_nxt.exc_done = exc_valid_in;
    st_nxt.exc_mode = 2'h0;
    if (exc_valid_in) begin
      if (nv2_eff || (nv_eff && !nv1_eff)) begin
        st_nxt.exc_mode = NVS_MODE_REDIR;
      end else begin
        st_nxt.exc_mode = NVS_MODE_NORMAL;
      end
    end

    // attribute combine; security of the stage 2 table does not gate it
    st_nxt.attr_done = attr_valid_in;
    st_nxt.fin_dev = s1_device_in;
    st_nxt.fin_kind = s1_dev_kind_in;
    st_nxt.fin_inner = s1_inner_in;
    st_nxt.fin_outer = s1_outer_in;
    if (st_r.forced_writeback) begin
      // bit 5 never read in this branch
      if (!s2_attr_in[4]) begin
        st_nxt.fin_dev = 1'b1;
        st_nxt.fin_kind = (s1_device_in && s1_dev_kind_in < s2_code) ?
          s1_dev_kind_in : s2_code;
      end else if (s2_code == 2'h3) begin
        st_nxt.fin_dev = s1_device_in;
      end else if (s2_code == 2'h2) begin
        st_nxt.fin_dev = 1'b0;
        st_nxt.fin_inner = NVS_CACHE_WB;
        st_nxt.fin_outer = NVS_CACHE_WB;
      end else if (!s1_device_in) begin
        st_nxt.fin_inner = NVS_CACHE_NC;
        st_nxt.fin_outer = NVS_CACHE_NC;
      end
    end else if (s2_attr_in[5:4] == 2'h0) begin
      // legacy: device stage 2 wins, stricter kind kept
      st_nxt.fin_dev = 1'b1;
      st_nxt.fin_kind = (s1_device_in && s1_dev_kind_in < s2_code) ?
        s1_dev_kind_in : s2_code;
    end
    if (st_nxt.fin_dev) begin
      st_nxt.fin_inner = NVS_CACHE_NC;
      st_nxt.fin_outer = NVS_CACHE_NC;
    end else begin
      st_nxt.fin_kind = 2'h0;
    end
    // allocation hint of a cacheable result
    if (!st_nxt.fin_dev && (st_nxt.fin_inner != NVS_CACHE_NC ||
        st_nxt.fin_outer != NVS_CACHE_NC)) begin
      st_nxt.fin_alloc = s1_cacheable ? s1_alloc_in : NVS_ALLOC_RWA;
    end else begin
      st_nxt.fin_alloc = 2'h0;
    end

    // descriptor reinterpretation
    st_nxt.desc_done = desc_valid_in;
    st_nxt.desc = desc_in;
    if (st_r.forced_writeback) begin
      st_nxt.desc[NVS_D_S2_IGN] = 1'b0;
    end
    if (desc_is_table_in) begin
      st_nxt.priv_execute_never = desc_in[NVS_D_TB_PXN];
      st_nxt.user_execute_never = desc_in[NVS_D_TB_UXN];
      if (both_nv && hier_perm_en_in) begin
        st_nxt.desc[NVS_D_TB_B61] = 1'b0;
        st_nxt.desc[NVS_D_TB_PXN] = 1'b0;
        st_nxt.priv_execute_never = desc_in[NVS_D_TB_UXN];
        st_nxt.user_execute_never = 1'b0;
      end
    end else begin
      st_nxt.priv_execute_never = desc_in[NVS_D_PG_PXN];
      st_nxt.user_execute_never = desc_in[NVS_D_PG_UXN];
      if (both_nv) begin
        st_nxt.desc[NVS_D_PG_PXN] = 1'b0;
        st_nxt.desc[NVS_D_PG_B6] = 1'b0;
        st_nxt.priv_execute_never = desc_in[NVS_D_PG_UXN];
        st_nxt.user_execute_never = 1'b0;
      end
    end

    // privilege state effects at guest kernel level
    st_nxt.pan_eff = priv_access_never_state_in &&
      !(both_nv && guest_kernel_level_in);
    st_nxt.unpriv_priv = both_nv && guest_kernel_level_in;
  end

  // state register; warm reset clears every field
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_out = st_r.rdata;
  assign acc_done_out = st_r.acc_done;
  assign acc_action_out = st_r.acc_action;
  assign acc_ec_out = st_r.acc_ec;
  assign exc_done_out = st_r.exc_done;
  assign exc_mode_out = st_r.exc_mode;
  assign attr_done_out = st_r.attr_done;
  assign fin_device_out = st_r.fin_dev;
  assign fin_dev_kind_out = st_r.fin_kind;
  assign fin_inner_out = st_r.fin_inner;
  assign fin_outer_out = st_r.fin_outer;
  assign fin_alloc_out = st_r.fin_alloc;
  assign desc_done_out = st_r.desc_done;
  assign desc_out = st_r.desc;
  assign priv_execute_never_out = st_r.priv_execute_never;
  assign user_execute_never_out = st_r.user_execute_never;
  assign pan_effective_out = st_r.pan_eff;
  assign unpriv_as_priv_out = st_r.unpriv_priv;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  chk_s2_bit5_ignored: assert property (
    desc_valid_in && st_r.forced_writeback |=> !desc_out[5]) else $error("bit 5 not ignored");
  chk_fwb_writeback: assert property (
    attr_valid_in && st_r.forced_writeback && s2_attr_in[4:2] == 3'h6
    |=> !fin_device_out && fin_inner_out == 2'h3 && fin_outer_out == 2'h3)
    else $error("forced write-back missing");
  chk_fwb_device_kept: assert property (
    attr_valid_in && st_r.forced_writeback && s2_attr_in[4:3] == 2'h2 && s1_device_in
    |=> fin_device_out && fin_dev_kind_out == $past(s1_dev_kind_in))
    else $error("stage 1 device lost");
  chk_alloc_default: assert property (
    attr_valid_in && !s1_cacheable ##1 !fin_device_out && fin_inner_out == 2'h3
    |-> fin_alloc_out == 2'h3) else $error("allocation hint wrong");
  chk_redirect_mode: assert property (
    exc_valid_in && st_r.nv2 && st_r.nv |=> exc_mode_out == 2'h2)
    else $error("mode bits not redirected");
  chk_redirect_gated: assert property (
    acc_valid_in && !st_r.nv && !st_r.nv1 |=> acc_action_out != 3'h2)
    else $error("transform without trap control");
  chk_xlate_trap: assert property (
    acc_valid_in && guest_kernel_level_in && hyp_level_enabled_in && st_r.at &&
    acc_implemented_in && !acc_other_trap_in && acc_kind_in == 3'h3 && !st_r.nv2
    |=> acc_action_out == 3'h1 && acc_ec_out == 6'h18) else $error("translate not trapped");
  chk_undef_first: assert property (
    acc_valid_in && guest_kernel_level_in && !acc_implemented_in && acc_kind_in != 3'h4
    |=> acc_done_out && acc_action_out == 3'h3) else $error("missing undefined");
  chk_pan_forced: assert property (
    st_r.nv && st_r.nv1 && guest_kernel_level_in ##1 st_r.nv && st_r.nv1
    |-> !pan_effective_out && unpriv_as_priv_out) else $error("access-never not cleared");
  chk_read_latency: assert property (
    reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out == 32'h0 ##1 reg_rdata_out == 32'h0
    || $past(reg_rd_in)) else $error("low word not zero");
  // secure stage 2 tables get the same forced write-back as non-secure ones
  chk_fwb_secure_s2: assert property (
    attr_valid_in && st_r.forced_writeback && s2_secure_in && s2_attr_in[4:2] == 3'h6
    |=> !fin_device_out && fin_inner_out == 2'h3) else $error("secure stage 2 not forced");
  // trap control without aux marks guest exceptions as redirected
  chk_trap_only_mode: assert property (
    exc_valid_in && st_r.nv && !st_r.nv1 |=> exc_mode_out == 2'h2)
    else $error("trap-only mode bits wrong");

endmodule : nvs_ctrl

/* File: core/nvs_pkg.sv */
// constants, types and encodings of the nested virtualisation / stage 2 attribute block
// assumes one 200 MHz clock and a plain 32-bit register port
package nvs_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] NVS_OFF_CFG_LO = 8'h00;
  localparam logic [7:0] NVS_OFF_CFG_HI = 8'h04;
  localparam logic [7:0] NVS_OFF_EFFECT = 8'h08;
  // field positions inside the upper config word (config bits 46..42)
  localparam int NVS_BIT_FWB = 14;
  localparam int NVS_BIT_NV2 = 13;
  localparam int NVS_BIT_AT = 12;
  localparam int NVS_BIT_NV1 = 11;
  localparam int NVS_BIT_NV = 10;
  // implemented-field mask, others read zero
  localparam logic [31:0] NVS_IMPL_MASK = 32'h0000_7C00;
  localparam logic [31:0] NVS_CFG_RESET = 32'h0000_0000;
  // aux-only behaviour: 0 as both one, 1 as both zero, 2 as defined
  localparam logic [1:0] NVS_AUX_ONLY_MODE = 2'h2;
  // syndrome class for nested traps
  localparam logic [5:0] NVS_EC_SYSREG = 6'h18;
  // saved mode bits [3:2]
  localparam logic [1:0] NVS_MODE_REDIR = 2'h2;
  localparam logic [1:0] NVS_MODE_NORMAL = 2'h1;
  // cacheability codes
  localparam logic [1:0] NVS_CACHE_NC = 2'h0;
  localparam logic [1:0] NVS_CACHE_WB = 2'h3;
  localparam logic [1:0] NVS_ALLOC_RWA = 2'h3;
  // descriptor bit positions
  localparam int NVS_D_S2_IGN = 5;
  localparam int NVS_D_PG_UXN = 54;
  localparam int NVS_D_PG_PXN = 53;
  localparam int NVS_D_PG_B6 = 6;
  localparam int NVS_D_TB_B61 = 61;
  localparam int NVS_D_TB_UXN = 60;
  localparam int NVS_D_TB_PXN = 59;
  // kinds of guest-kernel access presented for classification
  typedef enum logic [2:0] {
    NVS_ACC_HYP_REG, NVS_ACC_ALIAS_REG, NVS_ACC_LISTED_REG, NVS_ACC_S1_XLATE, NVS_ACC_OTHER
  } nvs_acc_kind_e;
  // outcome of an access
  typedef enum logic [2:0] {
    NVS_ACT_NONE, NVS_ACT_TRAP, NVS_ACT_TRANSFORM, NVS_ACT_UNDEF, NVS_ACT_OTHER_TRAP
  } nvs_action_e;
endpackage : nvs_pkg

/* File: sim/tb_nvs_ctrl.sv */
// self-checking bench of nvs_ctrl: register port, access traps, attributes, descriptors
// assumes nvs_ctrl answers each query one cycle after its strobe and 0x04 holds the fields
`timescale 1ns/100ps
module tb_nvs_ctrl import nvs_pkg::*;;
  logic clk_sys_in, rst_n_in, reg_wr_in, reg_rd_in, acc_valid_in, acc_implemented_in;
  logic acc_other_trap_in, guest_kernel_level_in, hyp_level_enabled_in, exc_valid_in;
  logic attr_valid_in, s1_device_in, s2_secure_in, desc_valid_in, desc_is_table_in;
  logic hier_perm_en_in, priv_access_never_state_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [2:0] acc_kind_in, acc_action_out;
  logic [1:0] s1_dev_kind_in, s1_inner_in, s1_outer_in, s1_alloc_in;
  logic [5:0] s2_attr_in;
  logic [63:0] desc_in;
  wire logic acc_done_out, exc_done_out, attr_done_out, fin_device_out, desc_done_out;
  wire logic priv_execute_never_out, user_execute_never_out, pan_effective_out;
  wire logic unpriv_as_priv_out;
  wire logic [5:0] acc_ec_out;
  wire logic [1:0] exc_mode_out, fin_dev_kind_out, fin_inner_out, fin_outer_out, fin_alloc_out;
  wire logic [63:0] desc_out;
  int num_errors = 0; // mismatches seen
  int checked = 0; // comparisons made
  nvs_ctrl uut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .guest_kernel_level_in(guest_kernel_level_in),
    .hyp_level_enabled_in(hyp_level_enabled_in), .acc_valid_in(acc_valid_in),
    .acc_kind_in(acc_kind_in), .acc_implemented_in(acc_implemented_in),
    .acc_other_trap_in(acc_other_trap_in), .acc_done_out(acc_done_out),
    .acc_action_out(acc_action_out), .acc_ec_out(acc_ec_out), .exc_valid_in(exc_valid_in),
    .exc_done_out(exc_done_out), .exc_mode_out(exc_mode_out), .attr_valid_in(attr_valid_in),
    .s1_device_in(s1_device_in), .s1_dev_kind_in(s1_dev_kind_in), .s1_inner_in(s1_inner_in),
    .s1_outer_in(s1_outer_in), .s1_alloc_in(s1_alloc_in), .s2_attr_in(s2_attr_in),
    .s2_secure_in(s2_secure_in), .attr_done_out(attr_done_out),
    .fin_device_out(fin_device_out), .fin_dev_kind_out(fin_dev_kind_out),
    .fin_inner_out(fin_inner_out), .fin_outer_out(fin_outer_out),
    .fin_alloc_out(fin_alloc_out), .desc_valid_in(desc_valid_in), .desc_in(desc_in),
    .desc_is_table_in(desc_is_table_in), .hier_perm_en_in(hier_perm_en_in),
    .desc_done_out(desc_done_out), .desc_out(desc_out),
    .priv_execute_never_out(priv_execute_never_out),
    .user_execute_never_out(user_execute_never_out),
    .priv_access_never_state_in(priv_access_never_state_in),
    .pan_effective_out(pan_effective_out), .unpriv_as_priv_out(unpriv_as_priv_out)
  );
  // free-running 200 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  // one comparison, reported at once on mismatch
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata_out);
  endtask : reg_rd
  // fields in order forced_writeback, redirect, translate trap, aux, trap control
  task automatic cfg(input logic [4:0] f);
    reg_wr(NVS_OFF_CFG_HI, 32'(f) << NVS_BIT_NV);
  endtask : cfg
  task automatic acc(input logic [2:0] k, input logic im, ot, gk, he, input logic [2:0] ea,
                     input logic [5:0] ee);
    @(posedge clk_sys_in);
    acc_kind_in <= k;
    acc_implemented_in <= im;
    acc_other_trap_in <= ot;
    guest_kernel_level_in <= gk;
    hyp_level_enabled_in <= he;
    acc_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    acc_valid_in <= 1'b0;
    #1 chk("acc_done", 64'h1, acc_done_out);
    chk("acc_action", ea, acc_action_out);
    chk("acc_ec", ee, acc_ec_out);
  endtask : acc
  task automatic exc(input logic [1:0] em);
    @(posedge clk_sys_in);
    guest_kernel_level_in <= 1'b1;
    exc_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    exc_valid_in <= 1'b0;
    #1 chk("exc_done", 64'h1, exc_done_out);
    chk("exc_mode", em, exc_mode_out);
  endtask : exc
  // device results compare kind only; cacheable results compare allocation too
  task automatic attr(input logic [5:0] s2, input logic sec, s1d, input logic [1:0] s1k, s1i,
                      s1o, s1a, input logic ed, input logic [1:0] ek, ei, eo, ea);
    @(posedge clk_sys_in);
    s2_attr_in <= s2;
    s2_secure_in <= sec;
    s1_device_in <= s1d;
    s1_dev_kind_in <= s1k;
    s1_inner_in <= s1i;
    s1_outer_in <= s1o;
    s1_alloc_in <= s1a;
    attr_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    attr_valid_in <= 1'b0;
    #1 chk("attr_done", 64'h1, attr_done_out);
    chk("fin_device", ed, fin_device_out);
    if (ed) begin
      chk("fin_dev_kind", ek, fin_dev_kind_out);
    end else begin
      chk("fin_inner", ei, fin_inner_out);
      chk("fin_outer", eo, fin_outer_out);
      if (ei != NVS_CACHE_NC) chk("fin_alloc", ea, fin_alloc_out);
    end
  endtask : attr
  task automatic desc(input logic [63:0] d, input logic tb, hp, input logic [63:0] eo,
                      input logic ep, eu);
    @(posedge clk_sys_in);
    desc_in <= d;
    desc_is_table_in <= tb;
    hier_perm_en_in <= hp;
    desc_valid_in <= 1'b1;
    @(posedge clk_sys_in);
    desc_valid_in <= 1'b0;
    #1 chk("desc_done", 64'h1, desc_done_out);
    chk("desc_out", eo, desc_out);
    chk("pxn", ep, priv_execute_never_out);
    chk("uxn", eu, user_execute_never_out);
  endtask : desc
  // these outputs follow their inputs one cycle late
  task automatic pan(input logic st, gk, ep, eu);
    @(posedge clk_sys_in);
    priv_access_never_state_in <= st;
    guest_kernel_level_in <= gk;
    repeat (2) @(posedge clk_sys_in);
    #1 chk("pan_effective", ep, pan_effective_out);
    chk("unpriv_as_priv", eu, unpriv_as_priv_out);
  endtask : pan
  task automatic t_regs;
    reg_rd(NVS_OFF_CFG_HI, NVS_CFG_RESET);
    reg_wr(NVS_OFF_CFG_HI, 32'hFFFF_FFFF);
    reg_rd(NVS_OFF_CFG_HI, NVS_IMPL_MASK);
    reg_wr(NVS_OFF_CFG_LO, 32'hFFFF_FFFF);
    reg_rd(NVS_OFF_CFG_LO, 32'h0000_0000);
    reg_rd(8'h40, 32'h0000_0000);
    cfg(5'h08);
    reg_rd(NVS_OFF_CFG_HI, 32'h0000_2000);
    reg_rd(NVS_OFF_EFFECT, 32'h0000_0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_trap;
    cfg(5'h04);
    acc(NVS_ACC_S1_XLATE, 1'b1, 1'b0, 1'b1, 1'b1, NVS_ACT_TRAP, NVS_EC_SYSREG);
    acc(NVS_ACC_S1_XLATE, 1'b1, 1'b0, 1'b1, 1'b0, NVS_ACT_NONE, 6'h00);
    acc(NVS_ACC_S1_XLATE, 1'b1, 1'b0, 1'b0, 1'b1, NVS_ACT_NONE, 6'h00);
    cfg(5'h02);
    acc(NVS_ACC_LISTED_REG, 1'b1, 1'b0, 1'b1, 1'b1, NVS_ACT_TRAP, NVS_EC_SYSREG);
    exc(NVS_MODE_NORMAL);
    cfg(5'h08);
    acc(NVS_ACC_HYP_REG, 1'b1, 1'b0, 1'b1, 1'b1, NVS_ACT_NONE, 6'h00);
    exc(NVS_MODE_NORMAL);
    cfg(5'h01);
    exc(NVS_MODE_REDIR);
    $display("test traps done");
  endtask : t_trap
  task automatic t_nest;
    cfg(5'h09);
    acc(NVS_ACC_HYP_REG, 1'b1, 1'b0, 1'b1, 1'b1, NVS_ACT_TRANSFORM, 6'h00);
    acc(NVS_ACC_ALIAS_REG, 1'b1, 1'b0, 1'b1, 1'b1, NVS_ACT_TRANSFORM, 6'h00);
    acc(NVS_ACC_HYP_REG, 1'b1, 1'b1, 1'b1, 1'b1, NVS_ACT_OTHER_TRAP, 6'h00);
    acc(NVS_ACC_HYP_REG, 1'b0, 1'b0, 1'b1, 1'b1, NVS_ACT_UNDEF, 6'h00);
    exc(NVS_MODE_REDIR);
    cfg(5'h0B);
    acc(NVS_ACC_HYP_REG, 1'b1, 1'b0, 1'b1, 1'b1, NVS_ACT_TRANSFORM, 6'h00);
    exc(NVS_MODE_REDIR);
    desc(64'h0060_0000_0000_0040, 1'b0, 1'b0, 64'h0040_0000_0000_0000, 1'b1, 1'b0);
    desc(64'h3800_0000_0000_0000, 1'b1, 1'b1, 64'h1000_0000_0000_0000, 1'b1, 1'b0);
    pan(1'b1, 1'b1, 1'b0, 1'b1);
    pan(1'b1, 1'b0, 1'b1, 1'b0);
    cfg(5'h00);
    pan(1'b1, 1'b1, 1'b1, 1'b0);
    desc(64'h0040_0000_0000_0000, 1'b0, 1'b0, 64'h0040_0000_0000_0000, 1'b0, 1'b1);
    $display("test nested done");
  endtask : t_nest
  task automatic t_attr;
    cfg(5'h10);
    attr(6'h3C, 1'b0, 1'b0, 2'h0, 2'h2, 2'h2, 2'h1, 1'b0, 2'h0, 2'h2, 2'h2, 2'h1);
    attr(6'h18, 1'b1, 1'b0, 2'h0, 2'h0, 2'h0, 2'h2, 1'b0, 2'h0, 2'h3, 2'h3, 2'h3);
    attr(6'h38, 1'b0, 1'b0, 2'h0, 2'h2, 2'h2, 2'h1, 1'b0, 2'h0, 2'h3, 2'h3, 2'h1);
    attr(6'h10, 1'b0, 1'b0, 2'h0, 2'h3, 2'h3, 2'h1, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0);
    attr(6'h14, 1'b1, 1'b1, 2'h2, 2'h0, 2'h0, 2'h0, 1'b1, 2'h2, 2'h0, 2'h0, 2'h0);
    for (int k = 0; k < 4; k++) begin
      attr(6'(k << 2), k[0], 1'b0, 2'h0, 2'h3, 2'h3, 2'h1, 1'b1, 2'(k), 2'h0, 2'h0, 2'h0);
    end
    desc(64'h0000_0000_0000_0020, 1'b0, 1'b0, 64'h0000_0000_0000_0000, 1'b0, 1'b0);
    $display("test attributes done");
  endtask : t_attr
  // second reset in mid-run clears the fields again
  task automatic t_reset;
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    reg_rd(NVS_OFF_CFG_HI, NVS_CFG_RESET);
    $display("test reset done");
  endtask : t_reset
  // prints the counts and the verdict, then ends the run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // cuts a hang short
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, acc_valid_in, acc_implemented_in} = '0;
    {acc_other_trap_in, guest_kernel_level_in, hyp_level_enabled_in, exc_valid_in} = '0;
    {attr_valid_in, s1_device_in, s2_secure_in, desc_valid_in, desc_is_table_in} = '0;
    {hier_perm_en_in, priv_access_never_state_in, reg_addr_in, reg_wdata_in} = '0;
    {acc_kind_in, s1_dev_kind_in, s1_inner_in, s1_outer_in, s1_alloc_in} = '0;
    {s2_attr_in, desc_in} = '0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_trap();
    t_nest();
    t_attr();
    t_reset();
    summarize();
  end
endmodule : tb_nvs_ctrl
